//--- core/usbbd_pkg.sv
// Purpose: shared constants and types of the buffer descriptor engine
// Assumes: 16-bit memory words, byte addresses
// Notes: descriptor field positions and answer codes
package usbbd_pkg;
    localparam int unsigned OWN_BIT = 15;
    localparam int unsigned TOGGLE_BIT = 14;
    localparam int unsigned CHECK_BIT = 11;
    localparam int unsigned STALL_BIT = 10;
    localparam int unsigned COUNT_W = 10;
    localparam int unsigned BD_INDEX_W = 6;
    localparam logic [15:0] STAT_OFFSET = 16'h0000;
    localparam logic [15:0] ADDR_OFFSET = 16'h0002;
    localparam logic [1:0] MODE_NO_PINGPONG = 2'h0;
    localparam logic [1:0] MODE_EP0_OUT = 2'h1;
    localparam logic [1:0] MODE_ALL = 2'h2;
    localparam logic [1:0] MODE_ALL_BUT_EP0 = 2'h3;
    localparam logic [1:0] ANS_ACK = 2'h0;
    localparam logic [1:0] ANS_NAK = 2'h1;
    localparam logic [1:0] ANS_STALL = 2'h2;
    localparam logic [1:0] ANS_DROP = 2'h3;

    typedef struct packed {
        logic [3:0] endpoint;
        logic tx;
        logic odd;
        logic [3:0] pid;
    } usbbd_token_type;

    typedef struct packed {
        logic [15:0] addr;
        logic write;
        logic [15:0] wdata;
    } usbbd_mem_type;
endpackage

//--- core/usbbd_bd_map.sv
// Purpose: endpoint to descriptor index mapping
// Assumes: mode from the buffering configuration register
// Notes: purely combinational
`timescale 1ns/100ps
module usbbd_bd_map (
    input wire logic [3:0] endpoint,
    input wire logic tx,
    input wire logic odd,
    input wire logic [1:0] mode,
    input wire logic hostMode,
    output logic [usbbd_pkg::BD_INDEX_W-1:0] index
);
    import usbbd_pkg::*;
    wire [3:0] ep = hostMode ? 4'h0 : endpoint; // RULE10
    wire [7:0] n = {4'h0, ep};
    wire [7:0] t = {7'h00, tx};
    wire [7:0] o = {7'h00, odd};
    wire isZero = (ep == 4'h0);
    wire [7:0] idx0 = (n << 1) + t; // RULE6
    wire [7:0] idx1 = isZero ? (tx ? 8'h02 : o) : (n << 1) + 8'h01 + t; // RULE7
    wire [7:0] idx2 = (n << 2) + (t << 1) + o; // RULE8
    wire [7:0] idx3 = isZero ? t : (n << 2) - 8'h02 + (t << 1) + o; // RULE9
    wire [7:0] sel = (mode == MODE_NO_PINGPONG) ? idx0 :
                     (mode == MODE_EP0_OUT) ? idx1 :
                     (mode == MODE_ALL) ? idx2 : idx3; // RULE5
    assign index = sel[BD_INDEX_W-1:0]; // RULE2
endmodule // usbbd_bd_map

//--- core/usbbd_skid.sv
// Purpose: small shift buffer with valid and ready on both sides
// Assumes: head entry always sits in slot 0
// Notes: outputs come straight from flops
`timescale 1ns/100ps
module usbbd_skid #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [DEPTH-1:0] vld_q;
    wire pop = vld_q[0] && outReady;
    wire push = inValid && !vld_q[DEPTH-1];
    wire [DEPTH-1:0] shifted = pop ? (vld_q >> 1) : vld_q;
    assign inReady = !vld_q[DEPTH-1];
    assign outValid = vld_q[0];
    assign outData = mem_q[0];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vld_q <= '0;
        end else begin
            vld_q <= shifted | (push ? (shifted + 1'b1) & ~shifted : '0);
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        wire [WIDTH-1:0] nextUp = (i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
        wire takeIn = push && !shifted[i] && (i == 0 || shifted[(i + DEPTH - 1) % DEPTH]);
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                mem_q[i] <= '0;
            end else if (takeIn) begin
                mem_q[i] <= inData;
            end else if (pop) begin
                mem_q[i] <= nextUp;
            end
        end
    end
endmodule // usbbd_skid

//--- core/usbbd_engine.sv
// Purpose: buffer descriptor engine between serial engine and system ram
// Assumes: memory port answers each read with one memRdValid pulse
// Notes: descriptors live in ram, reached only through the dma port
//
// Behaviour
// RULE1: software places table on 512-byte boundary
// RULE2: descriptor is two words, 64 descriptors
// RULE3: buffer addresses reach first 64 Kbytes only
// RULE4: software sizes table between 8 and 256 bytes
// RULE5: index from endpoint, direction, buffering mode
// RULE6: mode 0 uses 2n out, 2n+1 in
// RULE7: mode 1 ping-pongs endpoint zero out only
// RULE8: mode 2 ping-pongs every endpoint both ways
// RULE9: mode 3 ping-pongs all but endpoint zero
// RULE10: host mode uses endpoint zero descriptors only
// RULE11: host receive reports remote source endpoint
// RULE12: host transmit addressed to token register endpoint
// RULE13: ownership bit gates module use of descriptor
// RULE14: status word readable by either owner
// RULE15: module overwrites status with pid and count
// RULE16: pid field written with token or handshake
// RULE17: count is limit in, actual bytes out
// RULE18: toggle bit selects data0 or data1
// RULE19: toggle check drops mismatched data when enabled
// RULE20: stall enable answers stall, descriptor untouched
// RULE21: own dma master fetches descriptors and data
// RULE22: software avoids reusing unused descriptor slots
// RULE23: transfer done flag after status write
// RULE24: descriptor i at base plus four i
`timescale 1ns/100ps
module usbbd_engine #(
    parameter int unsigned TX_DEPTH = 2
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] tablePointerReg,
    input wire logic [1:0] bufferingMode,
    input wire logic hostMode,
    input wire logic tokValid,
    input wire usbbd_pkg::usbbd_token_type tokIn,
    output logic tokReady,
    output logic memValid,
    input wire logic memReady,
    output usbbd_pkg::usbbd_mem_type memReq,
    input wire logic memRdValid,
    input wire logic [15:0] memRdData,
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txByte,
    input wire logic linkDone,
    input wire logic [3:0] linkPid,
    input wire logic rxValid,
    output logic rxReady,
    input wire logic [7:0] rxByte,
    input wire logic rxEnd,
    input wire logic rxToggle,
    output logic ansValid,
    output logic [1:0] ansCode,
    output logic [15:0] endpointStallFlag,
    output logic transferDoneFlag,
    output logic [3:0] lastEndpointField,
    output logic [3:0] remoteEndpoint
);
    import usbbd_pkg::*;

    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_STAT = 10'h002,
        S_ADDR = 10'h004,
        S_TX_RD = 10'h008,
        S_TX_PUSH = 10'h010,
        S_TX_END = 10'h020,
        S_RX = 10'h040,
        S_RX_WR = 10'h080,
        S_STAT_WR = 10'h100,
        S_WAIT = 10'h200
    } usbbd_state_type;

    usbbd_state_type state_q;
    usbbd_token_type tok_q;
    usbbd_mem_type mem_q;
    logic memValid_q;
    logic [15:0] stat_q;
    logic [15:0] bufAddr_q;
    logic [BD_INDEX_W-1:0] index_q;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] limit_q;
    logic [15:0] word_q;
    logic byteHi_q;
    logic endSeen_q;
    logic rxReady_q;
    logic [3:0] pidNew_q;
    logic ansValid_q;
    logic [1:0] ansCode_q;
    logic [15:0] stallFlag_q;
    logic done_q;
    logic [3:0] lastEp_q;
    logic [3:0] remoteEp_q;

    // index and address decode
    wire [BD_INDEX_W-1:0] newIndex;
    usbbd_bd_map u_map (
        .endpoint(tokIn.endpoint),
        .tx(tokIn.tx),
        .odd(tokIn.odd),
        .mode(bufferingMode),
        .hostMode(hostMode),
        .index(newIndex)
    );
    wire [15:0] tableBase = {tablePointerReg, 8'h00}; // RULE1
    wire [15:0] newEntry = tableBase + {8'h00, newIndex, 2'b00}; // RULE24
    wire [15:0] entryAddr = tableBase + {8'h00, index_q, 2'b00}; // RULE24
    wire memAccept = memValid_q && memReady;
    wire [15:0] statCount = {6'h00, stat_q[COUNT_W-1:0]};
    wire ownedByModule = memRdData[OWN_BIT]; // RULE13
    wire stallEnabled = memRdData[STALL_BIT]; // RULE20
    wire toggleBad = stat_q[CHECK_BIT] && (rxToggle != stat_q[TOGGLE_BIT]); // RULE18 RULE19
    wire [COUNT_W-1:0] countNext = count_q + 1'b1;
    wire [15:0] txWordAddr = bufAddr_q + {6'h00, countNext}; // RULE3
    wire [15:0] rxWordAddr = bufAddr_q + {6'h00, count_q[COUNT_W-1:1], 1'b0}; // RULE3
    wire [15:0] statusOut = {1'b0, stat_q[TOGGLE_BIT], pidNew_q, count_q}; // RULE15 RULE16 RULE17 RULE18
    wire rxTake = rxValid && rxReady_q;
    wire rxRoom = count_q < limit_q; // RULE17
    wire [3:0] rxPid = hostMode ? linkPid : tok_q.pid; // RULE16
    // transmit and stall decode
    wire txLastByte = (countNext == limit_q);
    wire [15:0] stallOneHot = 16'h0001 << tok_q.endpoint;
    // dma request launch points
    wire statWrite = (state_q == S_STAT_WR);
    wire rxLastWord = (state_q == S_RX) && !rxTake && rxEnd && !toggleBad && byteHi_q;

    // transmit byte buffer toward the serial engine
    wire bufInValid = (state_q == S_TX_PUSH);
    wire bufInReady;
    wire [7:0] bufInData = byteHi_q ? word_q[15:8] : word_q[7:0];
    wire pushed = bufInValid && bufInReady;
    wire txWordEnd = pushed && !txLastByte && byteHi_q;
    usbbd_skid #(
        .WIDTH(8),
        .DEPTH(TX_DEPTH)
    ) u_txbuf (
        .clock(clock),
        .sys_rst(sys_rst),
        .inValid(bufInValid),
        .inReady(bufInReady),
        .inData(bufInData),
        .outValid(txValid),
        .outReady(txReady),
        .outData(txByte)
    );

    assign tokReady = state_q[0];
    assign memValid = memValid_q;
    assign memReq = mem_q;
    assign rxReady = rxReady_q;
    assign ansValid = ansValid_q;
    assign ansCode = ansCode_q;
    assign endpointStallFlag = stallFlag_q;
    assign transferDoneFlag = done_q;
    assign lastEndpointField = lastEp_q;
    assign remoteEndpoint = remoteEp_q;

    // dma request holding
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            memValid_q <= 1'b0;
        end else if (memAccept) begin
            memValid_q <= 1'b0;
        end else if (state_q == S_IDLE && tokValid) begin
            memValid_q <= 1'b1; // RULE21
        end else if (state_q == S_STAT && memRdValid && ownedByModule && !stallEnabled) begin
            memValid_q <= 1'b1;
        end else if (state_q == S_ADDR && memRdValid && tok_q.tx && statCount != 16'h0000) begin
            memValid_q <= 1'b1;
        end else if (state_q == S_TX_PUSH && txWordEnd) begin
            memValid_q <= 1'b1;
        end else if (statWrite) begin
            memValid_q <= 1'b1; // RULE15
        end else if (state_q == S_RX && rxTake && rxRoom && byteHi_q) begin
            memValid_q <= 1'b1;
        end else if (rxLastWord) begin
            memValid_q <= 1'b1;
        end
    end

    // main sequence
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            tok_q <= '0;
            mem_q <= '0;
            stat_q <= 16'h0000;
            bufAddr_q <= 16'h0000;
            index_q <= '0;
            count_q <= '0;
            limit_q <= '0;
            word_q <= 16'h0000;
            byteHi_q <= 1'b0;
            endSeen_q <= 1'b0;
            rxReady_q <= 1'b0;
            pidNew_q <= 4'h0;
            ansValid_q <= 1'b0;
            ansCode_q <= ANS_ACK;
            stallFlag_q <= 16'h0000;
            done_q <= 1'b0;
            lastEp_q <= 4'h0;
            remoteEp_q <= 4'h0;
        end else begin
            ansValid_q <= 1'b0;
            done_q <= 1'b0;
            stallFlag_q <= 16'h0000;
            unique case (state_q)
                S_IDLE: begin
                    if (tokValid) begin
                        tok_q <= tokIn;
                        index_q <= newIndex;
                        mem_q <= '{addr: newEntry + STAT_OFFSET, write: 1'b0, wdata: 16'h0000}; // RULE14
                        if (hostMode && tokIn.tx) begin
                            remoteEp_q <= tokIn.endpoint; // RULE12
                        end
                        state_q <= S_STAT;
                    end
                end
                S_STAT: begin
                    if (memRdValid) begin
                        stat_q <= memRdData;
                        if (!ownedByModule) begin
                            ansValid_q <= 1'b1; // RULE13
                            ansCode_q <= ANS_NAK;
                            state_q <= S_IDLE;
                        end else if (stallEnabled) begin
                            ansValid_q <= 1'b1; // RULE20
                            ansCode_q <= ANS_STALL;
                            stallFlag_q <= stallOneHot; // RULE20
                            state_q <= S_IDLE;
                        end else begin
                            mem_q <= '{addr: entryAddr + ADDR_OFFSET, write: 1'b0, wdata: 16'h0000}; // RULE2
                            state_q <= S_ADDR;
                        end
                    end
                end
                S_ADDR: begin
                    if (memRdValid) begin
                        bufAddr_q <= memRdData;
                        limit_q <= stat_q[COUNT_W-1:0]; // RULE17
                        count_q <= '0;
                        byteHi_q <= 1'b0;
                        endSeen_q <= 1'b0;
                        if (!tok_q.tx) begin
                            rxReady_q <= 1'b1;
                            state_q <= S_RX;
                        end else if (statCount == 16'h0000) begin
                            state_q <= S_TX_END;
                        end else begin
                            mem_q <= '{addr: memRdData, write: 1'b0, wdata: 16'h0000}; // RULE21
                            state_q <= S_TX_RD;
                        end
                    end
                end
                S_TX_RD: begin
                    if (memRdValid) begin
                        word_q <= memRdData;
                        state_q <= S_TX_PUSH;
                    end
                end
                S_TX_PUSH: begin
                    if (pushed) begin
                        count_q <= countNext;
                        byteHi_q <= !byteHi_q;
                        if (txLastByte) begin
                            state_q <= S_TX_END;
                        end else if (byteHi_q) begin
                            mem_q <= '{addr: txWordAddr, write: 1'b0, wdata: 16'h0000};
                            state_q <= S_TX_RD;
                        end
                    end
                end
                S_TX_END: begin
                    if (linkDone) begin
                        pidNew_q <= hostMode ? linkPid : tok_q.pid; // RULE16
                        state_q <= S_STAT_WR;
                    end
                end
                S_RX: begin
                    if (rxTake) begin
                        if (rxRoom) begin
                            count_q <= countNext; // RULE17
                            byteHi_q <= !byteHi_q;
                            if (byteHi_q) begin
                                rxReady_q <= 1'b0;
                                mem_q <= '{addr: rxWordAddr, write: 1'b1, wdata: {rxByte, word_q[7:0]}};
                                state_q <= S_RX_WR;
                            end else begin
                                word_q <= {8'h00, rxByte};
                            end
                        end
                    end else if (rxEnd) begin
                        rxReady_q <= 1'b0;
                        pidNew_q <= rxPid;
                        if (hostMode) begin
                            lastEp_q <= tok_q.endpoint; // RULE11
                        end
                        if (toggleBad) begin
                            ansValid_q <= 1'b1; // RULE19
                            ansCode_q <= ANS_DROP;
                            state_q <= S_IDLE;
                        end else if (byteHi_q) begin
                            endSeen_q <= 1'b1;
                            mem_q <= '{addr: rxWordAddr, write: 1'b1, wdata: word_q};
                            state_q <= S_RX_WR;
                        end else begin
                            state_q <= S_STAT_WR;
                        end
                    end
                end
                S_RX_WR: begin
                    if (memAccept) begin
                        if (endSeen_q) begin
                            state_q <= S_STAT_WR;
                        end else begin
                            rxReady_q <= 1'b1;
                            state_q <= S_RX;
                        end
                    end
                end
                S_STAT_WR: begin
                    mem_q <= '{addr: entryAddr + STAT_OFFSET, write: 1'b1, wdata: statusOut}; // RULE15
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (memAccept) begin
                        done_q <= 1'b1; // RULE23
                        ansValid_q <= 1'b1;
                        ansCode_q <= ANS_ACK;
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // usbbd_engine

//--- testbench/usbbd_mem_model.sv
// Purpose: system ram behind the descriptor engine dma port
// Assumes: one read answer pulse per accepted read
// Notes: slow input halves the accept rate
`timescale 1ns/100ps
module usbbd_mem_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic memValid,
    output logic memReady,
    input wire usbbd_pkg::usbbd_mem_type memReq,
    output logic memRdValid,
    output logic [15:0] memRdData
);
    import usbbd_pkg::*;
    // 16-bit words over the whole 64 Kbyte space
    logic [15:0] ram [0:32767];
    logic phase_q;
    assign memReady = !slow || phase_q;
    always @(posedge clock) begin
        phase_q <= sys_rst ? 1'b0 : !phase_q;
        memRdValid <= 1'b0;
        // an idle data bus never keeps the last word
        memRdData <= sys_rst ? 16'h0000 : ~memRdData;
        if (!sys_rst && memValid && memReady) begin
            if (memReq.write) begin
                ram[memReq.addr[15:1]] <= memReq.wdata;
            end else begin
                memRdValid <= 1'b1;
                memRdData <= ram[memReq.addr[15:1]];
            end
        end
    end
endmodule // usbbd_mem_model

//--- testbench/usbbd_engine_chk.sv
// Purpose: port checker of the descriptor engine
// Assumes: one clock, synchronous reset
// Notes: bound to every usbbd_engine
`timescale 1ns/100ps
module usbbd_engine_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] tablePointerReg,
    input wire logic hostMode,
    input wire logic tokValid,
    input wire logic tokReady,
    input wire logic memValid,
    input wire logic memReady,
    input wire usbbd_pkg::usbbd_mem_type memReq,
    input wire logic ansValid,
    input wire logic [1:0] ansCode,
    input wire logic [15:0] endpointStallFlag,
    input wire logic transferDoneFlag
);
    import usbbd_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire logic tokTaken = tokValid && tokReady;
    wire logic memTaken = memValid && memReady;
    wire logic stallOrNak = ansValid && (ansCode == ANS_STALL || ansCode == ANS_NAK);
    logic wrSeen_q;
    wire logic wrSeen_d = tokTaken ? 1'b0 : (wrSeen_q || (memTaken && memReq.write));
    always_ff @(posedge clock) begin
        wrSeen_q <= sys_rst ? 1'b0 : wrSeen_d;
    end
    property p_stat_read;
        tokTaken |=> memValid && !memReq.write && memReq.addr[15:8] == tablePointerReg && memReq.addr[1:0] == 2'h0;
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status read misplaced");
    property p_host_ep0;
        tokTaken && hostMode |=> memReq.addr[7:4] == 4'h0;
    endproperty
    a_host_ep0: assert property (p_host_ep0) else $error("host used a non zero descriptor");
    property p_req_hold;
        memValid && !memReady |=> memValid && $stable(memReq);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("dma request changed before accept");
    property p_done;
        transferDoneFlag |-> ansValid && ansCode == ANS_ACK && $past(memTaken && memReq.write && !memReq.wdata[OWN_BIT]);
    endproperty
    a_done: assert property (p_done) else $error("done without status write");
    property p_stall;
        endpointStallFlag != 16'h0000 |-> ansValid && ansCode == ANS_STALL && $onehot(endpointStallFlag);
    endproperty
    a_stall: assert property (p_stall) else $error("stall flag without stall answer");
    property p_stall_flag;
        ansValid && ansCode == ANS_STALL |-> endpointStallFlag != 16'h0000;
    endproperty
    a_stall_flag: assert property (p_stall_flag) else $error("stall answer without flag");
    property p_no_write;
        stallOrNak |-> !wrSeen_q && !(memTaken && memReq.write);
    endproperty
    a_no_write: assert property (p_no_write) else $error("memory written on refused token");
    property p_tbl_write;
        memTaken && memReq.write && memReq.addr[15:8] == tablePointerReg |-> memReq.addr[1:0] == 2'h0 && !memReq.wdata[OWN_BIT];
    endproperty
    a_tbl_write: assert property (p_tbl_write) else $error("status write keeps ownership");
    c_host: cover property (tokTaken && hostMode);
    c_done: cover property (transferDoneFlag);
    c_drop: cover property (ansValid && ansCode == ANS_DROP);
endmodule // usbbd_engine_chk
bind usbbd_engine usbbd_engine_chk u_chk (.clock, .sys_rst, .tablePointerReg, .hostMode, .tokValid, .tokReady,
    .memValid, .memReady, .memReq, .ansValid, .ansCode, .endpointStallFlag, .transferDoneFlag);

//--- testbench/tb_top.sv
// Purpose: self-checking bench of the descriptor engine
// Assumes: ram model on the dma port, bench drives the link side
// Notes: tables on 512-byte boundaries, buffers outside them
`timescale 1ns/100ps
module tb_top;
    import usbbd_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] tablePointerReg = 8'h12;
    logic [1:0] bufferingMode = 2'h0;
    logic hostMode = 1'b0, tokValid = 1'b0, slow = 1'b0, txReady = 1'b0, linkDone = 1'b0;
    logic rxValid = 1'b0, rxEnd = 1'b0, rxToggle = 1'b0;
    logic [3:0] linkPid = 4'h0;
    logic [7:0] rxByte = 8'h00;
    usbbd_token_type tokIn = '0;
    usbbd_mem_type memReq;
    logic tokReady, memValid, memReady, memRdValid, txValid, rxReady, ansValid, transferDoneFlag;
    logic [15:0] memRdData, endpointStallFlag;
    logic [7:0] txByte;
    logic [1:0] ansCode;
    logic [3:0] lastEndpointField, remoteEndpoint;
    int nFail = 0;
    int checkCount = 0;
    usbbd_engine dut (.clock, .sys_rst, .tablePointerReg, .bufferingMode, .hostMode, .tokValid, .tokIn, .tokReady,
        .memValid, .memReady, .memReq, .memRdValid, .memRdData, .txValid, .txReady, .txByte, .linkDone, .linkPid,
        .rxValid, .rxReady, .rxByte, .rxEnd, .rxToggle, .ansValid, .ansCode, .endpointStallFlag, .transferDoneFlag,
        .lastEndpointField, .remoteEndpoint);
    usbbd_mem_model mem (.clock, .sys_rst, .slow, .memValid, .memReady, .memReq, .memRdValid, .memRdData);
    initial forever #2 clock = ~clock;
    task automatic finish_test();
        if (nFail == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [5:0] bd_index(input logic [1:0] m, input logic [3:0] n, input logic t, input logic o);
        int e;
        e = int'(n);
        if (m == 2'h0) return 6'(2 * e + t);
        if (m == 2'h1) return (n == 4'h0) ? (t ? 6'h02 : 6'(o)) : 6'(2 * e + 1 + t);
        if (m == 2'h2) return 6'(4 * e + 2 * t + o);
        return (n == 4'h0) ? 6'(t) : 6'(4 * e - 2 + 2 * t + o);
    endfunction
    function automatic logic [14:0] word_of(input logic [5:0] i);
        logic [15:0] a;
        a = {tablePointerReg, 8'h00} + {8'h00, i, 2'h0};
        return a[15:1];
    endfunction
    task automatic send_token(input logic [3:0] ep, input logic t, input logic o, input logic [3:0] pid);
        tokValid <= 1'b1;
        tokIn <= '{endpoint: ep, tx: t, odd: o, pid: pid};
        @(posedge clock);
        for (int i = 0; i < 50 && tokReady !== 1'b1; i++) @(posedge clock);
        tokValid <= 1'b0;
    endtask
    task automatic wait_ans(input logic [1:0] exp);
        for (int i = 0; i < 300 && ansValid !== 1'b1; i++) @(posedge clock);
        check("answer", {12'h000, transferDoneFlag, ansValid, ansCode}, {12'h000, exp == ANS_ACK, 1'b1, exp});
    endtask
    task automatic test_mapping();
        logic [14:0] w;
        logic [3:0] ep;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 12; k++) begin
                ep = (k < 4) ? 4'h0 : ((k < 8) ? 4'h1 : 4'hf);
                w = word_of(bd_index(2'(m), ep, k[1], k[0]));
                mem.ram[w] = 16'h0000;
                bufferingMode <= 2'(m);
                send_token(ep, k[1], k[0], 4'h1);
                for (int i = 0; i < 300 && memValid !== 1'b1; i++) @(posedge clock);
                check("status read address", memReq.addr, {w, 1'b0});
                wait_ans(ANS_NAK);
            end
        end
    endtask
    task automatic test_tx(input logic host);
        logic [14:0] w;
        int n = 0;
        w = word_of(bd_index(2'h2, host ? 4'h0 : 4'h6, 1'b1, 1'b1));
        // descriptor handed over whole; not touched again while owned
        mem.ram[w] = 16'hc003;
        mem.ram[w + 1] = 16'h1000;
        mem.ram[15'h0800] = 16'h2211;
        mem.ram[15'h0801] = 16'h4433;
        hostMode <= host;
        slow <= host;
        bufferingMode <= 2'h2;
        send_token(4'h6, 1'b1, 1'b1, 4'h9);
        for (int i = 0; i < 300 && n < 3; i++) begin
            txReady <= i[1];
            @(posedge clock);
            if (txValid === 1'b1 && txReady === 1'b1) begin
                check("tx byte", 16'(txByte), 16'(8'h11 * (n + 1)));
                n++;
            end
        end
        txReady <= 1'b0;
        linkPid <= 4'h2;
        linkDone <= 1'b1;
        @(posedge clock);
        linkDone <= 1'b0;
        wait_ans(ANS_ACK);
        check("tx status", mem.ram[w], {2'b01, host ? 4'h2 : 4'h9, 10'h003});
        if (host) check("remote endpoint", 16'(remoteEndpoint), 16'h0006);
    endtask
    task automatic test_rx(input logic host, input logic chk, input logic tog, input logic [1:0] exp);
        logic [14:0] w;
        logic [15:0] st;
        w = word_of(bd_index(2'h3, host ? 4'h0 : 4'h2, 1'b0, 1'b0));
        st = 16'hc003 | {4'h0, chk, 11'h000};
        mem.ram[w] = st;
        mem.ram[w + 1] = 16'h1100;
        hostMode <= host;
        slow <= chk;
        bufferingMode <= 2'h3;
        send_token(4'h2, 1'b0, 1'b0, 4'h5);
        for (int k = 0; k < 3; k++) begin
            rxValid <= 1'b1;
            rxByte <= 8'(8'ha1 + 17 * k);
            @(posedge clock);
            for (int i = 0; i < 300 && rxReady !== 1'b1; i++) @(posedge clock);
        end
        rxValid <= 1'b0;
        rxEnd <= 1'b1;
        rxToggle <= tog;
        @(posedge clock);
        rxEnd <= 1'b0;
        wait_ans(exp);
        if (exp == ANS_DROP) st[OWN_BIT] = 1'b1;
        else st = {2'b01, host ? 4'h0 : 4'h5, 10'h003};
        check("rx status", mem.ram[w] & (host ? 16'hc3ff : 16'hffff), st);
        check("rx word 0", mem.ram[15'h0880], 16'hb2a1);
        check("rx word 1", mem.ram[15'h0881], 16'h00c3);
        if (host) check("source endpoint", 16'(lastEndpointField), 16'h0002);
    endtask
    task automatic test_stall();
        logic [14:0] w;
        w = word_of(6'h13);
        mem.ram[w] = 16'h8405;
        hostMode <= 1'b0;
        bufferingMode <= 2'h0;
        send_token(4'h9, 1'b1, 1'b0, 4'h9);
        wait_ans(ANS_STALL);
        check("stall flag", endpointStallFlag, 16'h0200);
        check("stalled status", mem.ram[w], 16'h8405);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        nFail++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        test_mapping();
        test_tx(1'b0);
        test_tx(1'b1);
        tablePointerReg <= 8'h40;
        @(posedge clock);
        test_rx(1'b0, 1'b1, 1'b1, ANS_ACK);
        test_rx(1'b0, 1'b1, 1'b0, ANS_DROP);
        test_rx(1'b0, 1'b0, 1'b0, ANS_ACK);
        test_rx(1'b1, 1'b0, 1'b1, ANS_ACK);
        test_stall();
        finish_test();
    end
endmodule // tb_top
